// [logic/bwoc_top.sv]
`timescale 1ns/1ps
`include "bwoc_regs.svh"
module bwoc_top #(
  parameter int N_IN       = 4,
  parameter int TICK_CYC   = `BWOC_TICK_CYC,
  parameter int FILTER_CYC = `BWOC_FILTER_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              system_domain_reset,
  input  wire logic [N_IN-1:0]   wake_inputs_n,
  input  wire logic              shutdown_in_n,
  input  wire logic              weekly_alarm_in,
  input  wire logic              clock_alarm_in,
  input  wire logic              main_power_good,
  input  wire logic              gpio_out_value,
  input  wire bwoc_pkg::bwoc_addr_t reg_addr,
  input  wire bwoc_pkg::bwoc_word_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output bwoc_pkg::bwoc_word_t   reg_rdata,
  output logic                   power_enable_out,
  output logic                   pin_battery_owned,
  output logic                   inhibit_n
);
  import bwoc_pkg::*;

  // ==================================================
  // register storage
  logic [N_IN-1:0] latch_en;
  logic            clock_alarm_hold_enable;
  logic            week_alarm_hold_enable;
  logic [N_IN-1:0] in_en;
  logic [N_IN-1:0] buf_en;
  logic [N_IN-1:0] pol;
  logic [7:0]      holdoff;
  logic [N_IN-1:0] rise_flag;
  logic [N_IN-1:0] fall_flag;
  logic            filter_bypass;
  logic            firmware_drive_select;
  logic            firmware_drive_value;
  logic            owner;
  logic [N_IN-1:0] in_latch;
  logic            clock_alarm_status;
  logic            weekly_alarm_status;

  // bus decode, writes blocked while system domain is in reset
  // a write that lands during system reset is dropped, not deferred
  logic bus_ok;
  logic wr_ctrl, wr_le, wr_ls, wr_ie, wr_ho, wr_pol, wr_rise, wr_fall, wr_be;
  assign bus_ok  = reg_wr && !system_domain_reset;
  assign wr_ctrl = bus_ok && (reg_addr == `BWOC_OFF_CTRL);
  assign wr_le   = bus_ok && (reg_addr == `BWOC_OFF_LATCH_EN);
  assign wr_ls   = bus_ok && (reg_addr == `BWOC_OFF_LATCH_RS);
  assign wr_ie   = bus_ok && (reg_addr == `BWOC_OFF_IN_EN);
  assign wr_ho   = bus_ok && (reg_addr == `BWOC_OFF_HOLDOFF);
  assign wr_pol  = bus_ok && (reg_addr == `BWOC_OFF_POL);
  assign wr_rise = bus_ok && (reg_addr == `BWOC_OFF_RISE);
  assign wr_fall = bus_ok && (reg_addr == `BWOC_OFF_FALL);
  assign wr_be   = bus_ok && (reg_addr == `BWOC_OFF_BUF_EN);

  // ==================================================
  // input path per wake input
  // order per input: filter, edge detect on the uninverted level, then
  // polarity, then latch; the status view depends on that order
  logic [N_IN-1:0] buf_on;
  logic [N_IN-1:0] filt;
  logic [N_IN-1:0] filt_d;
  logic [N_IN-1:0] asserted;
  logic [N_IN-1:0] status_in;
  logic [N_IN-1:0] contrib;
  logic [N_IN-1:0] clr_in;
  logic [N_IN-1:0] rise_ev;
  logic [N_IN-1:0] fall_ev;

  assign buf_on = in_en | buf_en;
  // polarity after the filter; pins are active low by default
  assign asserted = (~filt) ^ pol;
  assign clr_in   = wr_ls ? reg_wdata[N_IN-1:0] : '0;
  // a live assertion shows at once, so a latched input adds no cycle
  // of delay between the pin and the output
  // latched or live view
  assign status_in = asserted | (latch_en & in_latch);
  // disabled inputs never reach the output
  assign contrib = status_in & in_en;
  // edges on filtered raw level, only while buffer is on
  assign rise_ev = buf_on & filt & ~filt_d;
  assign fall_ev = buf_on & ~filt & filt_d;

  // glitch filters, one counter per input
  // the counter restarts whenever the pin agrees with the filtered level,
  // so with filter_bypass clear, only a level that stands FILTER_CYC cycles gets through;
  // limitation: chatter slower than that window still passes
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_in
      logic [15:0] cnt;
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt        <= 16'h0000;
          filt[gi]   <= 1'b1;
          filt_d[gi] <= 1'b1;
        end
        else
        begin
          filt_d[gi] <= filt[gi];
          if (filter_bypass || wake_inputs_n[gi] == filt[gi])
          begin
            cnt      <= 16'h0000;
            filt[gi] <= wake_inputs_n[gi];
          end
          else if (cnt >= 16'(FILTER_CYC - 1))
          begin
            cnt      <= 16'h0000;
            filt[gi] <= wake_inputs_n[gi];
          end
          else
            cnt <= cnt + 16'h0001;
        end
      end
    end
  endgenerate

  // ==================================================
  // source latches; set beats the clear
  // hold until reset bit, live source wins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      in_latch <= '0;
    else
      in_latch <= (in_latch & ~clr_in) | asserted;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_alarm_status  <= 1'b0;
      weekly_alarm_status <= 1'b0;
    end
    else
    begin
      clock_alarm_status <= (clock_alarm_status && !(wr_ls && reg_wdata[`BWOC_BIT_CLK_ALARM]))
                            || (clock_alarm_in && clock_alarm_hold_enable);
      weekly_alarm_status <= (weekly_alarm_status
                              && !(wr_ls && reg_wdata[`BWOC_BIT_WEEK_ALARM]))
                             || (weekly_alarm_in && week_alarm_hold_enable);
    end
  end

  // sticky edge flags, edge beats a write-one clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_flag <= '0;
      fall_flag <= '0;
    end
    else
    begin
      rise_flag <= (rise_flag & ~(wr_rise ? reg_wdata[N_IN-1:0] : '0)) | rise_ev;
      fall_flag <= (fall_flag & ~(wr_fall ? reg_wdata[N_IN-1:0] : '0)) | fall_ev;
    end
  end

  // ==================================================
  // power on inhibit timer
  bwoc_inh_state_t inh_state;
  logic [7:0]      inh_cnt;
  logic [31:0]     tick_cnt;
  logic            tick;
  logic            shdn_d;
  logic            shdn_fall;
  assign tick      = (tick_cnt == 32'(TICK_CYC - 1));
  assign shdn_fall = shdn_d && !shutdown_in_n;

  // the prescaler sits at zero while idle, so the first tick of an
  // inhibit comes one full period after the load, never early;
  // one prescaler serves all counts, as only one inhibit runs at a time
  // 8 Hz tick from core clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= 32'h0000_0000;
    else if (tick || inh_state == BWOC_IDLE)
      tick_cnt <= 32'h0000_0000;
    else
      tick_cnt <= tick_cnt + 32'h0000_0001;
  end

  // a shutdown that falls while inhibiting does not restart the count;
  // rewriting the holdoff to zero ends an inhibit in progress
  // load on shutdown, count ticks to zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inh_state <= BWOC_IDLE;
      inh_cnt   <= 8'h00;
      shdn_d    <= 1'b1;
    end
    else
    begin
      shdn_d <= shutdown_in_n;
      unique case (inh_state)
        BWOC_IDLE:
          if (shdn_fall && holdoff != 8'h00)
          begin
            inh_cnt   <= holdoff;
            inh_state <= BWOC_INHIBIT;
          end
        BWOC_INHIBIT:
          if (holdoff == 8'h00)
            inh_state <= BWOC_IDLE;
          else if (tick)
          begin
            inh_cnt <= inh_cnt - 8'h01;
            if (inh_cnt == 8'h01)
              inh_state <= BWOC_IDLE;
          end
        default:
          inh_state <= BWOC_IDLE;
      endcase
    end
  end

  // ==================================================
  // output selection
  logic hw_req, week_src, clk_src, next_out, drive_fw;

  // alarm source: live level, or the held status while latching;
  // the live term keeps a held alarm from lagging its own set by a cycle
  assign week_src = weekly_alarm_in || (week_alarm_hold_enable && weekly_alarm_status);
  assign clk_src  = clock_alarm_in || (clock_alarm_hold_enable && clock_alarm_status);
  assign hw_req   = (|contrib) || week_src || clk_src;
  // with the core rail down the hardware sources take over at once,
  // without any register write
  // firmware source only with main power
  assign drive_fw = firmware_drive_select && main_power_good;
  assign next_out = drive_fw ? firmware_drive_value : (hw_req && inh_state == BWOC_IDLE);

  // registered so the pin never glitches while its sources change
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      power_enable_out <= 1'b0;
    else
      power_enable_out <= next_out;
  end

  // low for the whole inhibit, straight from the state flop
  assign inhibit_n = (inh_state == BWOC_IDLE);
  // battery function forced when core power is down
  assign pin_battery_owned = owner || !main_power_good;

  // ==================================================
  // control registers
  // these bits change only by a write; reset values follow rst_n alone
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filter_bypass           <= 1'b0;
      firmware_drive_select   <= 1'b0;
      firmware_drive_value    <= 1'b0;
      owner                   <= `BWOC_RST_OWNER;
      latch_en                <= '0;
      clock_alarm_hold_enable <= 1'b0;
      week_alarm_hold_enable  <= 1'b0;
      in_en                   <= '0;
      buf_en                  <= '0;
      pol                     <= '0;
      holdoff                 <= `BWOC_RST_HOLDOFF;
    end
    else
    begin
      if (wr_ctrl)
      begin
        filter_bypass         <= reg_wdata[`BWOC_BIT_BYPASS];
        firmware_drive_select <= reg_wdata[`BWOC_BIT_FW_SEL];
        firmware_drive_value  <= reg_wdata[`BWOC_BIT_FW_VAL];
        owner                 <= reg_wdata[`BWOC_BIT_OWNER];
      end
      if (wr_le)
      begin
        latch_en                <= reg_wdata[N_IN-1:0];
        clock_alarm_hold_enable <= reg_wdata[`BWOC_BIT_CLK_ALARM];
        week_alarm_hold_enable  <= reg_wdata[`BWOC_BIT_WEEK_ALARM];
      end
      if (wr_ie)
        in_en <= reg_wdata[N_IN-1:0];
      if (wr_be)
        buf_en <= reg_wdata[N_IN-1:0];
      if (wr_pol)
        pol <= reg_wdata[N_IN-1:0];
      if (wr_ho)
        holdoff <= reg_wdata[7:0];
    end
  end

  // ==================================================
  // read path, one cycle latency, unmapped reads zero
  // the latch reset word is write only and reads as zero, and reads
  // during system reset return zero rather than stale data
  bwoc_word_t rd_mux;
  bwoc_word_t ctrl_word;
  assign ctrl_word = {14'h0000, clock_alarm_status, weekly_alarm_status, 3'h0,
                      filter_bypass, firmware_drive_select, firmware_drive_value,
                      power_enable_out, 1'b0, owner, 3'h0, 4'(status_in)};
  assign rd_mux =
    (reg_addr == `BWOC_OFF_CTRL)     ? ctrl_word :
    (reg_addr == `BWOC_OFF_LATCH_EN) ? {14'h0000, clock_alarm_hold_enable,
                                        week_alarm_hold_enable, 12'h000, 4'(latch_en)} :
    (reg_addr == `BWOC_OFF_IN_EN)    ? {28'h0000000, 4'(in_en)} :
    (reg_addr == `BWOC_OFF_HOLDOFF)  ? {24'h000000, holdoff} :
    (reg_addr == `BWOC_OFF_POL)      ? {28'h0000000, 4'(pol)} :
    (reg_addr == `BWOC_OFF_RISE)     ? {28'h0000000, 4'(rise_flag)} :
    (reg_addr == `BWOC_OFF_FALL)     ? {28'h0000000, 4'(fall_flag)} :
    (reg_addr == `BWOC_OFF_BUF_EN)   ? {28'h0000000, 4'(buf_en)} :
    32'h0000_0000;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd && !system_domain_reset)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0000_0000;
  end

  // gpio_out_value reserved for the gpio pad mux outside
  // the pad mux picks it whenever pin_battery_owned is low
  logic unused_gpio;
  assign unused_gpio = gpio_out_value;
endmodule

// [logic/bwoc_regs.svh]
`ifndef BWOC_REGS_SVH
`define BWOC_REGS_SVH
// ==================================================
// register offsets
`define BWOC_OFF_CTRL     8'h00
`define BWOC_OFF_LATCH_EN 8'h04
`define BWOC_OFF_LATCH_RS 8'h08
`define BWOC_OFF_IN_EN    8'h0c
`define BWOC_OFF_HOLDOFF  8'h10
`define BWOC_OFF_POL      8'h14
`define BWOC_OFF_RISE     8'h18
`define BWOC_OFF_FALL     8'h1c
`define BWOC_OFF_BUF_EN   8'h20
// ==================================================
// control word fields
`define BWOC_BIT_CLK_ALARM  17
`define BWOC_BIT_WEEK_ALARM 16
`define BWOC_BIT_BYPASS     12
`define BWOC_BIT_FW_SEL     11
`define BWOC_BIT_FW_VAL     10
`define BWOC_BIT_OUT        9
`define BWOC_BIT_OWNER      7
// ==================================================
// reset values
`define BWOC_RST_OWNER    1'b1
`define BWOC_RST_LATCH_EN 4'h0
`define BWOC_RST_HOLDOFF  8'h00
// ==================================================
// timing
`define BWOC_SLOW_CLK_HZ  32768
`define BWOC_TICK_HZ      8
`define BWOC_CORE_CLK_HZ  100000000
`define BWOC_FILTER_NS    1000
`define BWOC_FILTER_CYC   ((`BWOC_FILTER_NS * (`BWOC_CORE_CLK_HZ / 1000000) + 999) / 1000)
`define BWOC_TICK_CYC     (`BWOC_CORE_CLK_HZ / `BWOC_TICK_HZ)
`define BWOC_SLOW_CYC     (`BWOC_CORE_CLK_HZ / `BWOC_SLOW_CLK_HZ)
`endif

// [logic/bwoc_pkg.sv]
package bwoc_pkg;
  typedef logic [31:0] bwoc_word_t;
  typedef logic [7:0]  bwoc_addr_t;
  typedef enum logic [1:0] {
    BWOC_IDLE    = 2'b01,
    BWOC_INHIBIT = 2'b10
  } bwoc_inh_state_t;
endpackage

// [tb/bwoc_assertions.sv]
`timescale 1ns/1ps
// ====
// port-level checks of the wake output control
module bwoc_checker #(
  parameter int TICK_CYC = 20
) (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 system_domain_reset,
  input wire logic                 shutdown_in_n,
  input wire logic                 weekly_alarm_in,
  input wire logic                 clock_alarm_in,
  input wire logic                 main_power_good,
  input wire bwoc_pkg::bwoc_addr_t reg_addr,
  input wire bwoc_pkg::bwoc_word_t reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire bwoc_pkg::bwoc_word_t reg_rdata,
  input wire logic                 power_enable_out,
  input wire logic                 pin_battery_owned,
  input wire logic                 inhibit_n
);
  import bwoc_pkg::*;
  logic       fw_sel;
  logic       fw_val;
  logic       own;
  logic [7:0] hold;
  int         inh_cnt;
  // shadow of written control fields; system reset blocks the bus
  wire ok_wr   = reg_wr && !system_domain_reset;
  wire hw_mode = !fw_sel || !main_power_good;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fw_sel  <= 1'b0;
      fw_val  <= 1'b0;
      own     <= 1'b1;
      hold    <= 8'h00;
      inh_cnt <= 0;
    end
    else
    begin
      if (ok_wr && reg_addr == 8'h00)
      begin
        fw_sel <= reg_wdata[11];
        fw_val <= reg_wdata[10];
        own    <= reg_wdata[7];
      end
      if (ok_wr && reg_addr == 8'h10)
        hold <= reg_wdata[7:0];
      inh_cnt <= inhibit_n ? 0 : inh_cnt + 1; // length of the current inhibit
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle;
    (!reg_rd || system_domain_reset) |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_out_read;
    reg_rd && !system_domain_reset && reg_addr == 8'h00
      |=> reg_rdata[9] == $past(power_enable_out);
  endproperty
  a_out_read: assert property (p_out_read) else $error("output bit wrong");
  property p_owner;
    pin_battery_owned == (own || !main_power_good);
  endproperty
  a_owner: assert property (p_owner) else $error("pin owner wrong");
  property p_hw_alarm;
    hw_mode && inhibit_n && (weekly_alarm_in || clock_alarm_in) |=> power_enable_out;
  endproperty
  a_hw_alarm: assert property (p_hw_alarm) else $error("alarm not driven");
  property p_fw_out;
    !hw_mode && inhibit_n |=> power_enable_out == $past(fw_val);
  endproperty
  a_fw_out: assert property (p_fw_out) else $error("firmware level lost");
  property p_inh_out;
    !inhibit_n && hw_mode |=> !power_enable_out;
  endproperty
  a_inh_out: assert property (p_inh_out) else $error("output during inhibit");
  property p_inh_start;
    hold != 8'h00 && inhibit_n && $fell(shutdown_in_n) |-> ##[1:3] !inhibit_n;
  endproperty
  a_inh_start: assert property (p_inh_start) else $error("inhibit late");
  property p_zero_hold;
    (hold == 8'h00) [*3] |-> inhibit_n;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("inhibit with zero count");
  property p_inh_max;
    !inhibit_n |-> inh_cnt < (hold + 1) * TICK_CYC;
  endproperty
  a_inh_max: assert property (p_inh_max) else $error("inhibit too long");
  property p_inh_min;
    $rose(inhibit_n) && hold != 8'h00 |-> inh_cnt >= (hold - 1) * TICK_CYC;
  endproperty
  a_inh_min: assert property (p_inh_min) else $error("inhibit too short");
  c_inh_end: cover property (!inhibit_n ##1 inhibit_n);
  c_fw_on: cover property (!hw_mode && power_enable_out);
  c_alarm_on: cover property (hw_mode && weekly_alarm_in ##1 power_enable_out);
endmodule

bind bwoc_top bwoc_checker #(.TICK_CYC(TICK_CYC)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .system_domain_reset(system_domain_reset),
  .shutdown_in_n(shutdown_in_n), .weekly_alarm_in(weekly_alarm_in),
  .clock_alarm_in(clock_alarm_in), .main_power_good(main_power_good),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .power_enable_out(power_enable_out),
  .pin_battery_owned(pin_battery_owned), .inhibit_n(inhibit_n)
);

// [tb/bwoc_far_side.sv]
`timescale 1ns/1ps
// ====
// switches, alarms and supply outside the block
module bwoc_far_side (
  input  wire logic core_clk,
  output logic [3:0] wake_inputs_n,
  output logic       shutdown_in_n,
  output logic       weekly_alarm_in,
  output logic       clock_alarm_in,
  output logic       main_power_good
);
  // idle levels: switches open, no alarm, core powered
  initial
  begin
    wake_inputs_n   = 4'hf;
    shutdown_in_n   = 1'b1;
    weekly_alarm_in = 1'b0;
    clock_alarm_in  = 1'b0;
    main_power_good = 1'b1;
  end
  // pins move just after an edge, all together
  task set(input logic [3:0] w, input logic sd, input logic wk, input logic ck,
           input logic pg);
    @(posedge core_clk);
    wake_inputs_n   <= w;
    shutdown_in_n   <= sd;
    weekly_alarm_in <= wk;
    clock_alarm_in  <= ck;
    main_power_good <= pg;
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import bwoc_pkg::*;
  localparam int TK = 20;
  logic       core_clk = 0, rst_n = 0, sdr = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  bwoc_addr_t reg_addr = '0;
  bwoc_word_t reg_wdata = '0;
  bwoc_word_t reg_rdata, ew[$], em[$];
  logic [3:0] wk_n;
  logic       sd_n, wka, cka, pg, pe, own, inh_n;
  int         fail_count = 0, cmp_count = 0, n, h;
  // ====
  // clock, partner and block
  always #5 core_clk = ~core_clk;
  bwoc_far_side far (.core_clk(core_clk), .wake_inputs_n(wk_n), .shutdown_in_n(sd_n),
    .weekly_alarm_in(wka), .clock_alarm_in(cka), .main_power_good(pg));
  bwoc_top #(.TICK_CYC(TK), .FILTER_CYC(3)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .system_domain_reset(sdr), .wake_inputs_n(wk_n), .shutdown_in_n(sd_n),
    .weekly_alarm_in(wka), .clock_alarm_in(cka), .main_power_good(pg),
    .gpio_out_value(1'b0), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_enable_out(pe),
    .pin_battery_owned(own), .inhibit_n(inh_n));
  // ====
  // shared tasks
  task chk(input bwoc_word_t got, input bwoc_word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task wr(input bwoc_addr_t a, input bwoc_word_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read notes the masked expectation; the monitor compares it
  task rd(input bwoc_addr_t a, input bwoc_word_t e, input bwoc_word_t m);
    @(posedge core_clk);
    ew.push_back(e);
    em.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk(reg_rdata & em.pop_front(), ew.pop_front());
  end
  // ====
  // main sequence
  initial
  begin
    void'($urandom(32'hd04a));
    cyc(6);
    rst_n <= 1'b1;
    rd(8'h00, 32'h80, 32'h3_0c80);
    rd(8'h10, 32'h0, 32'hff);
    rd(8'h24, 32'h0, '1);
    rd(8'h08, 32'h0, '1);
    wr(8'h0c, 32'h1);
    wr(8'h20, 32'hc);
    far.set(4'b1000, 1, 0, 0, 1);
    cyc(10);
    chk(32'(pe), 32'h1);
    far.set(4'hf, 1, 0, 0, 1);
    cyc(10);
    chk(32'(pe), 32'h0);
    rd(8'h18, 32'h5, 32'hf);
    rd(8'h1c, 32'h5, 32'hf);
    wr(8'h18, 32'hf);
    wr(8'h1c, 32'hf);
    far.set(4'b0111, 1, 0, 0, 1);
    far.set(4'hf, 1, 0, 0, 1);
    cyc(8);
    rd(8'h1c, 32'h0, 32'hf);
    wr(8'h00, 32'h1080);
    far.set(4'b0111, 1, 0, 0, 1);
    far.set(4'hf, 1, 0, 0, 1);
    cyc(8);
    rd(8'h1c, 32'h8, 32'hf);
    wr(8'h14, 32'h1);
    cyc(8);
    chk(32'(pe), 32'h1);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h1_0000);
    far.set(4'hf, 1, 1, 0, 1);
    cyc(2);
    wr(8'h08, 32'h1_0000);
    far.set(4'hf, 1, 0, 0, 1);
    cyc(3);
    rd(8'h00, 32'h1_0200, 32'h3_0200);
    wr(8'h08, 32'h1_0000);
    cyc(2);
    rd(8'h00, 32'h0, 32'h3_0200);
    far.set(4'hf, 1, 0, 1, 1);
    cyc(2);
    rd(8'h00, 32'h200, 32'h3_0200);
    far.set(4'hf, 1, 0, 0, 1);
    wr(8'h00, 32'h1480);
    wr(8'h00, 32'h1c80);
    cyc(2);
    chk(32'(pe), 32'h1);
    wr(8'h00, 32'h1880);
    far.set(4'hf, 1, 0, 1, 1);
    cyc(2);
    chk(32'(pe), 32'h0);
    wr(8'h00, 32'h1800);
    far.set(4'hf, 1, 0, 1, 0);
    cyc(2);
    chk({30'h0, pe, own}, 32'h3);
    far.set(4'hf, 1, 0, 1, 1);
    cyc(2);
    chk(32'(own), 32'h0);
    wr(8'h00, 32'h1080);
    sdr <= 1'b1;
    rd(8'h10, 32'h0, '1);
    wr(8'h10, 32'h5);
    sdr <= 1'b0;
    rd(8'h10, 32'h0, 32'hff);
    h = $urandom_range(4, 1);
    wr(8'h10, 32'(h));
    far.set(4'hf, 0, 0, 1, 1);
    for (n = 0; n < 5 && inh_n; n++)
      cyc(1);
    chk(32'(n < 5), 32'h1);
    if (n == 5)
      end_of_test();
    cyc(2);
    chk(32'(pe), 32'h0);
    for (n = 0; n < 200 && !inh_n; n++)
      cyc(1);
    chk(32'(n + 2 >= (h - 1) * TK && n + 2 <= (h + 1) * TK), 32'h1);
    if (n == 200)
      end_of_test();
    cyc(2);
    chk(32'(pe), 32'h1);
    far.set(4'hf, 1, 0, 1, 1);
    wr(8'h10, 32'h0);
    far.set(4'hf, 0, 0, 1, 1);
    cyc(4);
    chk(32'(inh_n), 32'h1);
    // latched input view: stale latch cleared, then one short pulse
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h1);
    far.set(4'he, 0, 0, 0, 1);
    far.set(4'hf, 0, 0, 0, 1);
    cyc(2);
    rd(8'h00, 32'h201, 32'h20f);
    wr(8'h08, 32'h1);
    rd(8'h00, 32'h0, 32'h20f);
    // both enables cleared before pins reused
    wr(8'h0c, 32'h0);
    wr(8'h20, 32'h0);
    far.set(4'h0, 0, 0, 0, 1);
    cyc(4);
    chk(32'(pe), 32'h0);
    rd(8'h1c, 32'h9, 32'hf);
    cyc(3);
    end_of_test();
  end
endmodule
